// >>> include/eeprom_cmd_pkg.sv
// Constants and types shared by the serial EEPROM command engine.
// Assumes a single 200 MHz system clock sampling all pins.
package eeprom_cmd_pkg;

  // ==========================================================
  // Clock and program cycle timing
  localparam int CLK_PERIOD_NS       = 5;
  localparam int WORD_PROG_TIME_US   = 4000;
  localparam int BULK_ERASE_TIME_US  = 8000;
  localparam int BULK_WRITE_TIME_US  = 16000;
  localparam int WORD_PROG_CYCLES    = WORD_PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BULK_ERASE_CYCLES   = BULK_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int BULK_WRITE_CYCLES   = BULK_WRITE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMER_BITS          = 22;

  // ==========================================================
  // Command fields
  localparam logic [1:0] OP_SPECIAL  = 2'h0;
  localparam logic [1:0] OP_WRITE    = 2'h1;
  localparam logic [1:0] OP_READ     = 2'h2;
  localparam logic [1:0] OP_ERASE    = 2'h3;
  localparam logic [1:0] SP_PROG_DIS = 2'h0;
  localparam logic [1:0] SP_BULK_WR  = 2'h1;
  localparam logic [1:0] SP_BULK_ER  = 2'h2;
  localparam logic [1:0] SP_PROG_EN  = 2'h3;

  // ==========================================================
  // Organisation and density
  localparam int ADDR_BITS_X8_SMALL  = 7;
  localparam int ADDR_BITS_X8_LARGE  = 9;
  localparam int DATA_BITS_X16       = 16;
  localparam int DATA_BITS_X8        = 8;
  localparam int BYTES_PER_KBIT      = 128;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================
  // Pin synchroniser bit positions
  localparam int SYNC_SEL  = 0;
  localparam int SYNC_SCLK = 1;
  localparam int SYNC_DIN  = 2;
  localparam int SYNC_WIDTH = 3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_READ, ST_DONE
  } state_type;

  typedef enum logic [2:0] {
    PK_NONE, PK_WORD_ERASE, PK_WORD_WRITE, PK_BULK_ERASE, PK_BULK_WRITE
  } prog_kind_type;

endpackage

// >>> sim/serial_eeprom_command_engine_tb.sv
// ==========================================================
// Self-checking bench for the serial EEPROM command engine.
// Assumes a 1 Kbit array and shortened program cycle lengths.
// ==========================================================
module serial_eeprom_command_engine_tb
  import eeprom_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WPL = 200;
  localparam int BEL = 400;
  localparam int BWL = 800;

  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       word_width_select = 1'b0;
  logic       select;
  logic       serial_clk;
  logic       serial_in;
  logic       serial_out;
  logic       serial_out_en;
  logic [7:0] mem [0:127];
  int         err_count = 0;
  int         checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  serial_eeprom_command_engine #(
    .DENSITY_KBIT   (1),
    .WORD_PROG_LEN  (WPL),
    .BULK_ERASE_LEN (BEL),
    .BULK_WRITE_LEN (BWL)
  ) uut (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .select            (select),
    .serial_clk        (serial_clk),
    .serial_in         (serial_in),
    .word_width_select (word_width_select),
    .serial_out        (serial_out),
    .serial_out_en     (serial_out_en)
  );

  serial_host_model host (
    .ref_clk       (ref_clk),
    .select        (select),
    .serial_clk    (serial_clk),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_en (serial_out_en)
  );

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmd(input int n, input logic [31:0] v);
    logic [31:0] g;
    host.shift(n, v, g);
    host.release_sel();
  endtask

  // Status poll; a refused command must show no status at all
  task automatic poll(input int len, input logic busy);
    int n;
    host.raise_sel();
    check(serial_out_en, busy);
    if (busy) begin
      check(serial_out, 1'b0);
      n = 61;
      while (serial_out !== 1'b1 && n < len + 40) begin
        @(posedge ref_clk);
        n++;
      end
      check(n >= len, 1'b1);
      check(serial_out, 1'b1);
    end
    host.release_sel();
  endtask

  task automatic rd8(input logic [6:0] a, input int words);
    logic [31:0] g;
    host.shift(10, {22'h0, 1'b1, OP_READ, a}, g);
    check(g[0], 1'b0);
    check(serial_out_en, 1'b1);
    for (int k = 0; k < words; k++) begin
      host.shift(8, 32'h0, g);
      check(g[7:0], mem[7'(a + k)]);
    end
    host.release_sel();
    check(serial_out_en, 1'b0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_idle();
    logic [31:0] g;
    check(serial_out_en, 1'b0);
    host.shift(5, 32'h0, g);
    check(serial_out_en, 1'b0);
    rd8(7'h05, 1);
  endtask

  task automatic t_locked();
    cmd(18, {14'h0, 1'b1, OP_WRITE, 7'h03, 8'h12});
    poll(0, 1'b0);
    rd8(7'h03, 1);
  endtask

  task automatic t_write();
    cmd(10, {22'h0, 1'b1, OP_SPECIAL, SP_PROG_EN, 5'h0});
    cmd(18, {14'h0, 1'b1, OP_WRITE, 7'h00, 8'hA5});
    mem[0] = 8'hA5;
    poll(WPL, 1'b1);
    cmd(18, {14'h0, 1'b1, OP_WRITE, 7'h01, 8'h5C});
    mem[1] = 8'h5C;
    poll(WPL, 1'b1);
    rd8(7'h7F, 3);
    cmd(10, {22'h0, 1'b1, OP_ERASE, 7'h00});
    mem[0] = 8'hFF;
    poll(WPL, 1'b1);
    rd8(7'h00, 2);
  endtask

  task automatic t_bulk();
    cmd(18, {14'h0, 1'b1, OP_SPECIAL, SP_BULK_WR, 5'h0, 8'h3C});
    foreach (mem[i]) mem[i] = 8'h3C;
    poll(BWL, 1'b1);
    rd8(7'h40, 2);
    cmd(10, {22'h0, 1'b1, OP_SPECIAL, SP_BULK_ER, 5'h0});
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    poll(BEL, 1'b1);
    rd8(7'h7E, 3);
  endtask

  task automatic t_cut();
    cmd(6, {26'h0, 1'b1, OP_WRITE, 3'h0});
    poll(0, 1'b0);
    rd8(7'h00, 1);
  endtask

  task automatic t_x16();
    logic [31:0] g;
    word_width_select <= 1'b1;
    cmd(25, {7'h0, 1'b1, OP_WRITE, 6'h02, 16'h1234});
    poll(WPL, 1'b1);
    host.shift(9, {23'h0, 1'b1, OP_READ, 6'h02}, g);
    check(g[0], 1'b0);
    host.shift(16, 32'h0, g);
    check(g[15:0], 16'h1234);
    host.release_sel();
    word_width_select <= 1'b0;
    mem[4] = 8'h34;
    mem[5] = 8'h12;
    rd8(7'h04, 2);
  endtask

  task automatic t_disable();
    cmd(14, {18'h0, 1'b1, OP_SPECIAL, SP_PROG_DIS, 5'h0, 4'hF});
    poll(0, 1'b0);
    cmd(18, {14'h0, 1'b1, OP_WRITE, 7'h02, 8'h00});
    poll(0, 1'b0);
    rd8(7'h02, 1);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    foreach (mem[i]) mem[i] = ERASED_BYTE;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_idle();
    t_locked();
    t_write();
    t_bulk();
    t_cut();
    t_x16();
    t_disable();
    tally_and_finish();
  end

  // Whole run needs well under 200 us; this leaves ample margin
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end
endmodule

// >>> sim/serial_host_model.sv
// ==========================================================
// Host side model: drives select, serial clock and data in.
// Assumes ref_clk is the bench clock; serial clock is 85 ns.
// ==========================================================
module serial_host_model (
  input  wire logic ref_clk,
  output logic      select,
  output logic      serial_clk,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_en
);
  timeunit 1ns;
  timeprecision 1ps;

  wire logic line_level;

  // Pull-up on the data out line: a floating output reads as one,
  // so a missing drive on a zero bit shows up as a mismatch
  assign line_level = serial_out_en ? serial_out : 1'b1;

  // Serial clock stands low outside frames
  initial begin
    select     = 1'b0;
    serial_clk = 1'b0;
    serial_in  = 1'b0;
  end

  // Shift n bits MSB first; capture serial_out before each fall
  task automatic shift(input int n, input logic [31:0] v,
                       output logic [31:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      select    <= 1'b1;
      serial_in <= v[i];
      repeat (8) @(posedge ref_clk);
      serial_clk <= 1'b1;
      repeat (8) @(posedge ref_clk);
      serial_clk <= 1'b0;
      got = {got[30:0], line_level};
    end
  endtask

  // Select drops before any further rise; held low past 250 ns
  task automatic release_sel();
    @(posedge ref_clk);
    select    <= 1'b0;
    serial_in <= ~serial_in;
    repeat (52) @(posedge ref_clk);
  endtask

  task automatic raise_sel();
    @(posedge ref_clk);
    select <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// >>> verilog/serial_eeprom_command_engine.sv
// Command engine of a three-wire serial EEPROM, storage in flip-flops.
// Assumes all pins are asynchronous to ref_clk; the serial clock is
// sampled and its rising edges found on ref_clk.
//
// Functional notes
// - Width select high gives 16-bit words, low gives 8-bit words.
// - Input bits are taken at each rising serial clock edge.
// - Output floats except during read data or status; select low floats it.
// - Status drives low while programming, high once ready.
// - Start bit is first rising edge with select and input high while not busy.
// - Before a start bit nothing happens; select high leaves standby.
// - A command runs only after all its bits arrive.
// - After the last bit, clock and input are ignored until select drops.
// - Start bit then opcode: 10 read, 01 write, 11 erase, 00 special.
// - Special group by top address bits: enable, bulk erase/write, disable.
// - Address field length depends on density and word width.
// - Total clock counts follow from address and data lengths.
// - Programming disabled after reset; erase and write refused until enabled.
// - Enable holds until disable; reads work either way.
// - Read gives a zero bit, then the word MSB first, on rising edges.
// - With select held high, reads continue at the next address.
// - Word erase sets all bits to one, starting at select falling edge.
// - Write takes data after address; select fall starts erase-then-program.
// - Status shows when select is raised again during a program cycle.
// - Bulk erase sets the array to ones, self-timed, no clocks needed.
// - Bulk write erases then fills every word, only when enabled.
// - Program cycles last 4 ms, 8 ms, 16 ms; busy for the whole cycle.
// - Select low resets command decoding and drops partial commands.
// - A started program cycle completes whatever select does.
module serial_eeprom_command_engine
  import eeprom_cmd_pkg::*;
#(
  parameter int DENSITY_KBIT      = 4,
  parameter int WORD_PROG_LEN     = eeprom_cmd_pkg::WORD_PROG_CYCLES,
  parameter int BULK_ERASE_LEN    = eeprom_cmd_pkg::BULK_ERASE_CYCLES,
  parameter int BULK_WRITE_LEN    = eeprom_cmd_pkg::BULK_WRITE_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic select,
  input  wire logic serial_clk,
  input  wire logic serial_in,
  input  wire logic word_width_select,
  output logic      serial_out,
  output logic      serial_out_en
);
  import eeprom_cmd_pkg::*;

  localparam int MEM_BYTES = DENSITY_KBIT * BYTES_PER_KBIT;
  localparam int AW8 = (DENSITY_KBIT == 1) ? ADDR_BITS_X8_SMALL
                                           : ADDR_BITS_X8_LARGE;
  localparam logic [8:0] MASK8  = 9'(MEM_BYTES - 1);
  localparam logic [8:0] MASK16 = 9'(MEM_BYTES / 2 - 1);

  typedef struct packed {
    logic [3:0]               sync1;
    logic [3:0]               sync2;
    logic                     sclk_prev;
    logic                     sel_prev;
    state_type                state;
    logic [4:0]               cnt;
    logic                     wide;
    logic [1:0]               opcode;
    logic [8:0]               addr;
    logic [15:0]              data;
    logic [15:0]              rd_word;
    prog_kind_type            pend;
    prog_kind_type            kind;
    logic                     busy;
    logic [TIMER_BITS-1:0]    timer;
    logic                     prog_en;
    logic                     status_on;
    logic                     dout;
    logic                     dout_en;
    logic [MEM_BYTES*8-1:0]   mem;
  } core_type;

  core_type st_reg;
  core_type st_next;
  logic [MEM_BYTES*8-1:0] mem_next;

  // ==========================================================
  // Synchronised pins and derived strobes
  logic sel_s;
  logic din_s;
  logic rise;
  logic apply;
  logic [4:0] alen_m1;
  logic [4:0] dlen_m1;
  logic [8:0] a_full;
  logic [8:0] a_inc;

  assign sel_s   = st_reg.sync2[SYNC_SEL];
  assign din_s   = st_reg.sync2[SYNC_DIN];
  assign rise    = st_reg.sync2[SYNC_SCLK] & ~st_reg.sclk_prev;
  assign apply   = st_reg.busy & (st_reg.timer == '0);
  assign alen_m1 = st_reg.wide ? 5'(AW8 - 2) : 5'(AW8 - 1);
  assign dlen_m1 = st_reg.wide ? 5'(DATA_BITS_X16 - 1)
                               : 5'(DATA_BITS_X8 - 1);
  assign a_full  = {st_reg.addr[7:0], din_s};
  assign a_inc   = (st_reg.addr + 9'h001)
                   & (st_reg.wide ? MASK16 : MASK8);

  function automatic logic [15:0] word_at(input logic [8:0] a,
                                          input logic w);
    int i;
    i = w ? 2 * int'(a & MASK16) : int'(a & MASK8);
    if (w) begin
      word_at = {st_reg.mem[(i + 1) * 8 +: 8], st_reg.mem[i * 8 +: 8]};
    end else begin
      word_at = {8'h00, st_reg.mem[i * 8 +: 8]};
    end
  endfunction

  // ==========================================================
  // Array update at the end of a program cycle
  // Applied in one cycle; the timer alone models the cell programming.
  for (genvar i = 0; i < MEM_BYTES; i++) begin : g_byte
    logic hit;
    logic [7:0] val;
    always_comb begin
      if (st_reg.wide) begin
        hit = (9'(i / 2) == (st_reg.addr & MASK16));
        val = (i % 2 == 1) ? st_reg.data[15:8] : st_reg.data[7:0];
      end else begin
        hit = (9'(i) == (st_reg.addr & MASK8));
        val = st_reg.data[7:0];
      end
      mem_next[i * 8 +: 8] = st_reg.mem[i * 8 +: 8];
      if (apply) begin
        case (st_reg.kind)
          PK_WORD_ERASE: if (hit) mem_next[i * 8 +: 8] = ERASED_BYTE;
          PK_WORD_WRITE: if (hit) mem_next[i * 8 +: 8] = val;
          PK_BULK_ERASE: mem_next[i * 8 +: 8] = ERASED_BYTE;
          PK_BULK_WRITE: mem_next[i * 8 +: 8] = val;
          default:       mem_next[i * 8 +: 8] = st_reg.mem[i * 8 +: 8];
        endcase
      end
    end
  end

  // ==========================================================
  // Command engine
  always_comb begin
    logic [1:0] sp;
    st_next = st_reg;
    sp = 2'(a_full >> (alen_m1 - 5'h01));
    st_next.sync1 = {word_width_select, serial_in, serial_clk, select};
    st_next.sync2 = st_reg.sync1;
    st_next.sclk_prev = st_reg.sync2[SYNC_SCLK];
    st_next.sel_prev = sel_s;
    st_next.mem = mem_next;
    if (st_reg.busy) begin
      if (apply) begin
        st_next.busy = 1'b0;
        st_next.kind = PK_NONE;
      end else begin
        st_next.timer = st_reg.timer - 1'b1;
      end
    end
    if (!sel_s) begin
      st_next.state = ST_IDLE;
      st_next.dout_en = 1'b0;
      st_next.dout = 1'b0;
      if (st_reg.sel_prev && st_reg.pend != PK_NONE) begin
        if (st_reg.prog_en && !st_reg.busy) begin
          st_next.busy = 1'b1;
          st_next.kind = st_reg.pend;
          st_next.status_on = 1'b1;
          case (st_reg.pend)
            PK_BULK_ERASE: st_next.timer = TIMER_BITS'(BULK_ERASE_LEN - 1);
            PK_BULK_WRITE: st_next.timer = TIMER_BITS'(BULK_WRITE_LEN - 1);
            default:       st_next.timer = TIMER_BITS'(WORD_PROG_LEN - 1);
          endcase
        end
        st_next.pend = PK_NONE;
      end
    end else begin
      if (st_reg.status_on && st_reg.state == ST_IDLE) begin
        st_next.dout_en = 1'b1;
        st_next.dout = ~st_reg.busy;
      end
      if (rise) begin
        case (st_reg.state)
          ST_IDLE: begin
            if (din_s && !st_reg.busy) begin
              st_next.state = ST_OPCODE;
              st_next.cnt = 5'h00;
              st_next.wide = st_reg.sync2[SYNC_WIDTH];
              st_next.status_on = 1'b0;
              st_next.dout_en = 1'b0;
              st_next.dout = 1'b0;
            end
          end
          ST_OPCODE: begin
            st_next.opcode = {st_reg.opcode[0], din_s};
            if (st_reg.cnt == 5'h01) begin
              st_next.state = ST_ADDR;
              st_next.cnt = 5'h00;
            end else begin
              st_next.cnt = st_reg.cnt + 5'h01;
            end
          end
          ST_ADDR: begin
            st_next.addr = a_full;
            if (st_reg.cnt == alen_m1) begin
              st_next.cnt = 5'h00;
              st_next.state = ST_DONE;
              case (st_reg.opcode)
                OP_READ: begin
                  st_next.state = ST_READ;
                  st_next.rd_word = word_at(a_full, st_reg.wide);
                  st_next.dout = 1'b0;
                  st_next.dout_en = 1'b1;
                end
                OP_WRITE: st_next.state = ST_DATA;
                OP_ERASE: st_next.pend = PK_WORD_ERASE;
                default: begin
                  case (sp)
                    SP_PROG_EN:  st_next.prog_en = 1'b1;
                    SP_PROG_DIS: st_next.prog_en = 1'b0;
                    SP_BULK_ER:  st_next.pend = PK_BULK_ERASE;
                    SP_BULK_WR:  st_next.state = ST_DATA;
                    default:     st_next.prog_en = st_reg.prog_en;
                  endcase
                end
              endcase
            end else begin
              st_next.cnt = st_reg.cnt + 5'h01;
            end
          end
          ST_DATA: begin
            st_next.data = {st_reg.data[14:0], din_s};
            if (st_reg.cnt == dlen_m1) begin
              st_next.state = ST_DONE;
              st_next.pend = (st_reg.opcode == OP_WRITE) ? PK_WORD_WRITE
                                                         : PK_BULK_WRITE;
            end else begin
              st_next.cnt = st_reg.cnt + 5'h01;
            end
          end
          ST_READ: begin
            st_next.dout = st_reg.rd_word[4'(dlen_m1 - st_reg.cnt)];
            if (st_reg.cnt == dlen_m1) begin
              st_next.cnt = 5'h00;
              st_next.addr = a_inc;
              st_next.rd_word = word_at(a_inc, st_reg.wide);
            end else begin
              st_next.cnt = st_reg.cnt + 5'h01;
            end
          end
          ST_DONE: st_next.state = ST_DONE;
          default: st_next.state = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st_reg <= '{sync1: 4'h0, sync2: 4'h0, sclk_prev: 1'b0,
                  sel_prev: 1'b0, state: ST_IDLE, cnt: 5'h00,
                  wide: 1'b0, opcode: 2'h0, addr: 9'h000,
                  data: 16'h0000, rd_word: 16'h0000, pend: PK_NONE,
                  kind: PK_NONE, busy: 1'b0, timer: '0,
                  prog_en: 1'b0, status_on: 1'b0, dout: 1'b0,
                  dout_en: 1'b0, mem: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_out    = st_reg.dout;
  assign serial_out_en = st_reg.dout_en;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  out_float_a: assert property (!sel_s |=> !serial_out_en)
    else $error("output driven while select low");
  busy_low_a: assert property (
    st_reg.status_on && st_reg.busy && !apply && sel_s
    && st_reg.state == ST_IDLE && !rise
    |=> serial_out_en && !serial_out)
    else $error("status not low while busy");
  start_seen_a: assert property (
    st_reg.state == ST_IDLE && sel_s && rise && din_s && !st_reg.busy
    |=> st_reg.state == ST_OPCODE)
    else $error("start bit missed");
  no_start_a: assert property (
    st_reg.state == ST_IDLE && rise && !din_s |=> st_reg.state == ST_IDLE)
    else $error("left idle without start bit");
  done_hold_a: assert property (
    st_reg.state == ST_DONE && sel_s |=> st_reg.state == ST_DONE)
    else $error("engine reacted after last bit");
  refuse_prog_a: assert property (
    !st_reg.busy && !st_reg.prog_en && !sel_s |=> !st_reg.busy)
    else $error("program cycle started while disabled");
  dummy_zero_a: assert property (
    $rose(st_reg.state == ST_READ) |-> serial_out_en && !serial_out)
    else $error("no leading zero on read");
  prog_len_a: assert property (
    $rose(st_reg.busy) |-> st_reg.timer == (st_reg.kind == PK_BULK_ERASE
      ? TIMER_BITS'(BULK_ERASE_LEN - 1) : st_reg.kind == PK_BULK_WRITE
      ? TIMER_BITS'(BULK_WRITE_LEN - 1) : TIMER_BITS'(WORD_PROG_LEN - 1)))
    else $error("wrong program cycle length");
  busy_hold_a: assert property (
    st_reg.busy && st_reg.timer != '0 |=> st_reg.busy)
    else $error("program cycle cut short");
  select_clear_a: assert property (
    !sel_s |=> st_reg.state == ST_IDLE)
    else $error("decoder not reset by select low");

endmodule
